// ===== pkg/qui_params.svh
// Constants for the two-wire target port of the four-UART bridge.
// Assumes a 10 MHz ref_clk; included by package and both ends.
`ifndef QUI_PARAMS_SVH
`define QUI_PARAMS_SVH

`define QUI_CLK_NS        100
`define QUI_SCL_PERIOD_NS 2000
// Quarter of an SCL period in ref_clk cycles, rounded down
`define QUI_QTR_CYC       ((`QUI_SCL_PERIOD_NS) / (4 * `QUI_CLK_NS))
`define QUI_ACK_BIT       4'h8
`define QUI_LAST_BIT      4'h7
`define QUI_FIFO_REG      8'h00
`define QUI_REG_LAST      8'h25
`define QUI_RW_READ       1'b1
`define QUI_STRAP_SETTLE  2'h3
// Upper three address bits per UART, UART3 in the top field
`define QUI_UART_HI       12'h2ae
// Strap pair index whose low address bits are swapped
`define QUI_IDX_GG        4'h0
`define QUI_IDX_SG        4'hc

`endif

// ===== pkg/qui_pkg.sv
// Types shared by the target end and the controller end.
// Assumes qui_params.svh is on the include path.
`include "qui_params.svh"

package qui_pkg;

  typedef enum logic [1:0] {
    QUI_STRAP_GND = 2'h0,
    QUI_STRAP_VL  = 2'h1,
    QUI_STRAP_SCL = 2'h2,
    QUI_STRAP_SDA = 2'h3
  } qui_strap_t;

  typedef enum logic [2:0] {
    QUI_T_IDLE = 3'h0,
    QUI_T_RECV = 3'h1,
    QUI_T_ACK  = 3'h2,
    QUI_T_SEND = 3'h3,
    QUI_T_MACK = 3'h4,
    QUI_T_WAIT = 3'h5
  } qui_tst_t;

  typedef enum logic [1:0] {
    QUI_K_ADDR = 2'h0,
    QUI_K_REG  = 2'h1,
    QUI_K_DATA = 2'h2
  } qui_kind_t;

  typedef enum logic [2:0] {
    QUI_H_IDLE  = 3'h0,
    QUI_H_START = 3'h1,
    QUI_H_TX    = 3'h2,
    QUI_H_RX    = 3'h3,
    QUI_H_STOP  = 3'h4
  } qui_hst_t;

  typedef enum logic [2:0] {
    QUI_Q_AW  = 3'h0,
    QUI_Q_REG = 3'h1,
    QUI_Q_WD  = 3'h2,
    QUI_Q_AR  = 3'h3,
    QUI_Q_RD  = 3'h4
  } qui_seq_t;

  typedef struct packed {
    qui_tst_t   st;
    qui_kind_t  kind;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic [7:0] rbuf;
    logic       rd_mode;
    logic       more;
    logic       strap_ok;
    logic [1:0] settle;
    logic [3:0] strap_s1;
    logic [3:0] strap_s2;
    logic [3:0] strap;
    logic       scl_s1;
    logic       scl_s2;
    logic       scl_d;
    logic       sda_s1;
    logic       sda_s2;
    logic       sda_d;
    logic       sda_oe;
    logic       irq_oe;
    logic       rd;
    logic       wr;
    logic [1:0] uart;
    logic [7:0] bus_addr;
    logic [7:0] wdata;
  } qui_tgt_state_t;

  typedef struct packed {
    qui_hst_t   st;
    qui_seq_t   seq;
    logic [1:0] q;
    logic [7:0] tick;
    logic [3:0] bitn;
    logic [7:0] shift;
    logic [7:0] left;
    logic [7:0] regad;
    logic [6:0] dev;
    logic       rd_cmd;
    logic       nack;
    logic       scl_oe;
    logic       sda_oe;
    logic       sda_s1;
    logic       sda_s2;
    logic       irq_s1;
    logic       irq_s2;
    logic       ready;
    logic       done;
    logic       err;
    logic       rd_valid;
    logic       wr_take;
    logic [7:0] rd_data;
  } qui_hst_state_t;

endpackage : qui_pkg

// ===== pkg/qui_if.sv
// Open-drain two-wire bus plus interrupt line between the two ends.
// Each wire rests high unless some party enables its low drive.
`timescale 1ns/1ps

interface qui_if;
  logic scl;
  logic sda;
  logic irq_n;
  logic ctl_scl_o;
  logic ctl_scl_oe;
  logic ctl_sda_o;
  logic ctl_sda_oe;
  logic tgt_sda_o;
  logic tgt_sda_oe;
  logic tgt_irq_o;
  logic tgt_irq_oe;

  // Pull-ups modelled as wired-AND of enabled drivers
  assign scl   = ctl_scl_oe ? ctl_scl_o : 1'b1;
  assign sda   = (ctl_sda_oe ? ctl_sda_o : 1'b1)
               & (tgt_sda_oe ? tgt_sda_o : 1'b1);
  assign irq_n = tgt_irq_oe ? tgt_irq_o : 1'b1;

  modport target (
    input  scl,
    input  sda,
    output tgt_sda_o,
    output tgt_sda_oe,
    output tgt_irq_o,
    output tgt_irq_oe
  );

  modport host (
    input  scl,
    input  sda,
    input  irq_n,
    output ctl_scl_o,
    output ctl_scl_oe,
    output ctl_sda_o,
    output ctl_sda_oe
  );
endinterface : qui_if

// ===== hw/qui_target.sv
// Target end of the two-wire port: address decode, register pointer,
// byte transfer and acknowledge towards the four UART register files.
// Assumes strap codes come from pad sensing and are static after reset.
//
// Behaviour
// - Answer a 7-bit address, sixteen devices per bus
// - Straps set address; four pairs pick UARTs
// - Address LSB one reads, zero writes
// - Controller sends address first after START
// - One bit per SCL, stable while high
// - SDA change during SCL high is control
// - Idle bus leaves both lines high
// - Controller ends with STOP or repeated START
// - Ack address; ack register only if valid
// - Single write: one byte, ack, STOP
// - Burst write: ack every byte until STOP
// - Read: write pointer, repeated START, read
// - Single read: controller nacks, then STOP
// - Burst read: send while acked, nack ends
// - Ack low through ninth clock high phase
// - Host polls known register until ready; qui_ctrl does no polling
// - Events drive open-drain low interrupt line
// - Host gates clocks of unused UARTs; here one clk_en freezes the whole port
// - Burst increments pointer except at FIFO port
`timescale 1ns/1ps
`include "qui_params.svh"

module qui_target #(
  parameter logic [7:0] REG_LAST = `QUI_REG_LAST
) (
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic                clk_en,
  qui_if.target                    bus,
  input  wire qui_pkg::qui_strap_t address_strap_upper,
  input  wire qui_pkg::qui_strap_t address_strap_lower,
  input  wire logic [3:0]          uart_event,
  input  wire logic [7:0]          reg_rdata,
  output logic                     reg_wr,
  output logic                     reg_rd,
  output logic [1:0]               reg_uart,
  output logic [7:0]               reg_addr,
  output logic [7:0]               reg_wdata
);
  import qui_pkg::*;

  // Named copy so the per-UART field can be part-selected
  localparam logic [11:0] UART_HI = `QUI_UART_HI;

  qui_tgt_state_t s_r;
  qui_tgt_state_t s_nxt;
  logic [3:0]     addr_hit;
  logic [3:0]     low_bits;
  logic           rise;
  logic           fall;
  logic           start_c;
  logic           stop_c;

  // FIFO port address holds still so bursts stream one FIFO
  function automatic logic [7:0] qui_next_ptr(input logic [7:0] p);
    qui_next_ptr = (p == `QUI_FIFO_REG) ? p : 8'(p + 8'h01);
  endfunction : qui_next_ptr

  // ******************************************************************
  // Address decode
  // ******************************************************************
  always_comb begin
    unique case (s_r.strap)
      `QUI_IDX_GG: low_bits = `QUI_IDX_SG;
      `QUI_IDX_SG: low_bits = `QUI_IDX_GG;
      default:     low_bits = s_r.strap;
    endcase
  end

  genvar k;
  generate
    for (k = 0; k < 4; k++) begin : g_uart
      assign addr_hit[k] = s_r.strap_ok
        && (s_r.shift[7:1] == {UART_HI[3*k +: 3], low_bits});
    end
  endgenerate

  // ******************************************************************
  // Edge and bus condition detection
  // ******************************************************************
  assign rise    = s_r.scl_s2 & ~s_r.scl_d;
  assign fall    = ~s_r.scl_s2 & s_r.scl_d;
  assign start_c = s_r.scl_s2 & s_r.scl_d & s_r.sda_d & ~s_r.sda_s2;
  assign stop_c  = s_r.scl_s2 & s_r.scl_d & ~s_r.sda_d & s_r.sda_s2;

  // ******************************************************************
  // Next state
  // ******************************************************************
  always_comb begin
    s_nxt          = s_r;
    s_nxt.rd       = 1'b0;
    s_nxt.wr       = 1'b0;
    s_nxt.scl_s1   = bus.scl;
    s_nxt.scl_s2   = s_r.scl_s1;
    s_nxt.scl_d    = s_r.scl_s2;
    s_nxt.sda_s1   = bus.sda;
    s_nxt.sda_s2   = s_r.sda_s1;
    s_nxt.sda_d    = s_r.sda_s2;
    s_nxt.strap_s1 = {address_strap_upper, address_strap_lower};
    s_nxt.strap_s2 = s_r.strap_s1;
    s_nxt.irq_oe   = |uart_event;
    if (s_r.rd) begin
      s_nxt.rbuf = reg_rdata;
    end
    // Straps settle past the synchroniser before the address is used
    if (!s_r.strap_ok) begin
      if (s_r.settle == `QUI_STRAP_SETTLE) begin
        s_nxt.strap    = s_r.strap_s2;
        s_nxt.strap_ok = 1'b1;
      end else begin
        s_nxt.settle = 2'(s_r.settle + 2'h1);
      end
    end

    if (start_c) begin
      // Repeated START restarts decode from any state
      s_nxt.st     = QUI_T_RECV;
      s_nxt.kind   = QUI_K_ADDR;
      s_nxt.cnt    = 4'h0;
      s_nxt.sda_oe = 1'b0;
    end else if (stop_c) begin
      s_nxt.st     = QUI_T_IDLE;
      s_nxt.sda_oe = 1'b0;
    end else begin
      unique case (s_r.st)
        QUI_T_IDLE, QUI_T_WAIT: begin
          s_nxt.sda_oe = 1'b0;
        end
        QUI_T_RECV: begin
          if (rise) begin
            s_nxt.shift = {s_r.shift[6:0], s_r.sda_s2};
            s_nxt.cnt   = 4'(s_r.cnt + 4'h1);
          end else if (fall && s_r.cnt == `QUI_ACK_BIT) begin
            s_nxt.cnt = 4'h0;
            s_nxt.st  = QUI_T_WAIT;
            unique case (s_r.kind)
              QUI_K_ADDR: begin
                if (|addr_hit) begin
                  s_nxt.st      = QUI_T_ACK;
                  s_nxt.sda_oe  = 1'b1;
                  s_nxt.rd_mode = (s_r.shift[0] == `QUI_RW_READ);
                  for (int i = 0; i < 4; i++) begin
                    if (addr_hit[i]) begin
                      s_nxt.uart = 2'(i);
                    end
                  end
                  if (s_r.shift[0] == `QUI_RW_READ) begin
                    s_nxt.rd       = 1'b1;
                    s_nxt.bus_addr = s_r.ptr;
                  end
                end
              end
              QUI_K_REG: begin
                s_nxt.ptr = s_r.shift;
                if (s_r.shift <= REG_LAST) begin
                  s_nxt.st     = QUI_T_ACK;
                  s_nxt.sda_oe = 1'b1;
                end
              end
              default: begin
                s_nxt.wr       = 1'b1;
                s_nxt.bus_addr = s_r.ptr;
                s_nxt.wdata    = s_r.shift;
                s_nxt.ptr      = qui_next_ptr(s_r.ptr);
                s_nxt.st       = QUI_T_ACK;
                s_nxt.sda_oe   = 1'b1;
              end
            endcase
          end
        end
        QUI_T_ACK: begin
          // Ack held until SCL falls after the ninth clock
          if (fall) begin
            s_nxt.sda_oe = 1'b0;
            if (s_r.rd_mode) begin
              s_nxt.st     = QUI_T_SEND;
              s_nxt.shift  = s_r.rbuf;
              s_nxt.sda_oe = ~s_r.rbuf[7];
              s_nxt.cnt    = 4'h0;
              s_nxt.ptr    = qui_next_ptr(s_r.ptr);
            end else begin
              s_nxt.st   = QUI_T_RECV;
              s_nxt.kind = (s_r.kind == QUI_K_ADDR) ? QUI_K_REG
                                                    : QUI_K_DATA;
            end
          end
        end
        QUI_T_SEND: begin
          // Data changes only while SCL is low
          if (fall) begin
            s_nxt.cnt = 4'(s_r.cnt + 4'h1);
            if (s_r.cnt == `QUI_LAST_BIT) begin
              s_nxt.sda_oe = 1'b0;
              s_nxt.st     = QUI_T_MACK;
            end else begin
              s_nxt.shift  = {s_r.shift[6:0], 1'b0};
              s_nxt.sda_oe = ~s_r.shift[6];
            end
          end
        end
        QUI_T_MACK: begin
          if (rise) begin
            s_nxt.more = ~s_r.sda_s2;
            if (!s_r.sda_s2) begin
              s_nxt.rd       = 1'b1;
              s_nxt.bus_addr = s_r.ptr;
            end
          end else if (fall) begin
            if (s_r.more) begin
              s_nxt.st     = QUI_T_SEND;
              s_nxt.shift  = s_r.rbuf;
              s_nxt.sda_oe = ~s_r.rbuf[7];
              s_nxt.cnt    = 4'h0;
              s_nxt.ptr    = qui_next_ptr(s_r.ptr);
            end else begin
              s_nxt.st = QUI_T_WAIT;
            end
          end
        end
      endcase
    end
  end

  // ******************************************************************
  // State register and outputs
  // ******************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r <= '0;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  assign bus.tgt_sda_o  = 1'b0;
  assign bus.tgt_sda_oe = s_r.sda_oe;
  assign bus.tgt_irq_o  = 1'b0;
  assign bus.tgt_irq_oe = s_r.irq_oe;
  assign reg_wr         = s_r.wr;
  assign reg_rd         = s_r.rd;
  assign reg_uart       = s_r.uart;
  assign reg_addr       = s_r.bus_addr;
  assign reg_wdata      = s_r.wdata;

endmodule : qui_target

// ===== hw/qui_ctrl.sv
// Controller end of the two-wire port: makes SCL by division and runs
// write and read transactions from a simple command port.
// Assumes no clock stretching by the target.
`timescale 1ns/1ps
`include "qui_params.svh"

module qui_ctrl (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  qui_if.host             bus,
  input  wire logic       cmd_valid,
  input  wire logic       cmd_read,
  input  wire logic [6:0] cmd_dev,
  input  wire logic [7:0] cmd_reg,
  input  wire logic [7:0] cmd_len,
  input  wire logic [7:0] wr_data,
  output logic            cmd_ready,
  output logic            wr_take,
  output logic [7:0]      rd_data,
  output logic            rd_valid,
  output logic            done,
  output logic            err,
  output logic            irq_seen
);
  import qui_pkg::*;

  localparam int QTR = `QUI_QTR_CYC;

  qui_hst_state_t s_r;
  qui_hst_state_t s_nxt;
  logic           qs;

  assign qs = (s_r.tick == 8'(QTR - 1));

  // ******************************************************************
  // Next state, one bus phase per quarter SCL period
  // ******************************************************************
  always_comb begin
    s_nxt          = s_r;
    s_nxt.done     = 1'b0;
    s_nxt.rd_valid = 1'b0;
    s_nxt.wr_take  = 1'b0;
    s_nxt.sda_s1   = bus.sda;
    s_nxt.sda_s2   = s_r.sda_s1;
    s_nxt.irq_s1   = bus.irq_n;
    s_nxt.irq_s2   = s_r.irq_s1;
    s_nxt.tick     = qs ? 8'h00 : 8'(s_r.tick + 8'h01);
    if (s_r.st == QUI_H_IDLE) begin
      s_nxt.tick   = 8'h00;
      s_nxt.q      = 2'h0;
      s_nxt.ready  = 1'b1;
      s_nxt.scl_oe = 1'b0;
      s_nxt.sda_oe = 1'b0;
      if (cmd_valid && s_r.ready) begin
        s_nxt.ready  = 1'b0;
        s_nxt.st     = QUI_H_START;
        s_nxt.seq    = QUI_Q_AW;
        s_nxt.dev    = cmd_dev;
        s_nxt.regad  = cmd_reg;
        s_nxt.left   = cmd_len;
        s_nxt.rd_cmd = cmd_read;
        s_nxt.nack   = 1'b0;
        s_nxt.err    = 1'b0;
      end
    end else if (qs) begin
      s_nxt.q = 2'(s_r.q + 2'h1);
      unique case (s_r.st)
        QUI_H_START: begin
          unique case (s_r.q)
            2'h0: s_nxt.sda_oe = 1'b0;
            2'h1: s_nxt.scl_oe = 1'b0;
            2'h2: s_nxt.sda_oe = 1'b1;
            default: begin
              s_nxt.scl_oe = 1'b1;
              s_nxt.st     = QUI_H_TX;
              s_nxt.bitn   = 4'h0;
              s_nxt.shift  = {s_r.dev, s_r.seq == QUI_Q_AR};
            end
          endcase
        end
        QUI_H_TX: begin
          unique case (s_r.q)
            2'h0: s_nxt.sda_oe = (s_r.bitn == `QUI_ACK_BIT) ? 1'b0
                                                           : ~s_r.shift[7];
            2'h1: s_nxt.scl_oe = 1'b0;
            2'h2: begin
              if (s_r.bitn == `QUI_ACK_BIT) begin
                s_nxt.nack = s_r.sda_s2;
              end
            end
            default: begin
              s_nxt.scl_oe = 1'b1;
              s_nxt.bitn   = 4'(s_r.bitn + 4'h1);
              s_nxt.shift  = {s_r.shift[6:0], 1'b0};
              if (s_r.bitn == `QUI_ACK_BIT) begin
                s_nxt.bitn = 4'h0;
                if (s_r.nack) begin
                  s_nxt.st  = QUI_H_STOP;
                  s_nxt.err = 1'b1;
                end else if (s_r.seq == QUI_Q_AW) begin
                  s_nxt.seq   = QUI_Q_REG;
                  s_nxt.shift = s_r.regad;
                end else if (s_r.seq == QUI_Q_AR) begin
                  s_nxt.seq = QUI_Q_RD;
                  s_nxt.st  = QUI_H_RX;
                end else if (s_r.seq == QUI_Q_REG && s_r.rd_cmd) begin
                  s_nxt.seq = QUI_Q_AR;
                  s_nxt.st  = QUI_H_START;
                end else if (s_r.left == 8'h00) begin
                  s_nxt.st = QUI_H_STOP;
                end else begin
                  s_nxt.seq     = QUI_Q_WD;
                  s_nxt.shift   = wr_data;
                  s_nxt.wr_take = 1'b1;
                  s_nxt.left    = 8'(s_r.left - 8'h01);
                end
              end
            end
          endcase
        end
        QUI_H_RX: begin
          unique case (s_r.q)
            // Ack every byte but the last, nack the last
            2'h0: s_nxt.sda_oe = (s_r.bitn == `QUI_ACK_BIT)
                                 && (s_r.left != 8'h00);
            2'h1: s_nxt.scl_oe = 1'b0;
            2'h2: begin
              if (s_r.bitn != `QUI_ACK_BIT) begin
                s_nxt.shift = {s_r.shift[6:0], s_r.sda_s2};
              end
            end
            default: begin
              s_nxt.scl_oe = 1'b1;
              s_nxt.bitn   = 4'(s_r.bitn + 4'h1);
              if (s_r.bitn == `QUI_LAST_BIT) begin
                s_nxt.rd_data  = s_r.shift;
                s_nxt.rd_valid = 1'b1;
                s_nxt.left     = 8'(s_r.left - 8'h01);
              end else if (s_r.bitn == `QUI_ACK_BIT) begin
                s_nxt.bitn = 4'h0;
                if (s_r.left == 8'h00) begin
                  s_nxt.st = QUI_H_STOP;
                end
              end
            end
          endcase
        end
        QUI_H_STOP: begin
          unique case (s_r.q)
            2'h0: s_nxt.sda_oe = 1'b1;
            2'h1: s_nxt.scl_oe = 1'b0;
            2'h2: s_nxt.sda_oe = 1'b0;
            default: begin
              s_nxt.st   = QUI_H_IDLE;
              s_nxt.done = 1'b1;
            end
          endcase
        end
        default: s_nxt.st = QUI_H_IDLE;
      endcase
    end
  end

  // ******************************************************************
  // State register and outputs
  // ******************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r <= '0;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  assign bus.ctl_scl_o  = 1'b0;
  assign bus.ctl_scl_oe = s_r.scl_oe;
  assign bus.ctl_sda_o  = 1'b0;
  assign bus.ctl_sda_oe = s_r.sda_oe;
  assign cmd_ready      = s_r.ready;
  assign wr_take        = s_r.wr_take;
  assign rd_data        = s_r.rd_data;
  assign rd_valid       = s_r.rd_valid;
  assign done           = s_r.done;
  assign err            = s_r.err;
  assign irq_seen       = ~s_r.irq_s2;

endmodule : qui_ctrl

// ===== dv/qui_chk.sv
// Bus-level assertions for the two-wire link between both ends.
// Assumes it sits beside the interface and samples on ref_clk.
`timescale 1ns/1ps

module qui_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic irq_n,
  input wire logic ctl_scl_oe,
  input wire logic ctl_sda_oe,
  input wire logic tgt_sda_o,
  input wire logic tgt_sda_oe,
  input wire logic tgt_irq_o,
  input wire logic tgt_irq_oe
);
  logic       scl_d_r, sda_d_r, busy_r, start, stop;
  logic [3:0] nb_r;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // ********
  // Bus condition tracking
  // ********
  assign start = scl && scl_d_r && sda_d_r && !sda;
  assign stop  = scl && scl_d_r && !sda_d_r && sda;

  // Rise count saturates at 15 so later bytes carry no constraint
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      busy_r  <= 1'b0;
      nb_r    <= 4'hf;
    end else begin
      scl_d_r <= scl;
      sda_d_r <= sda;
      if (start) begin
        busy_r <= 1'b1;
        nb_r   <= 4'h0;
      end else begin
        if (stop) begin
          busy_r <= 1'b0;
        end
        if (scl && !scl_d_r && nb_r != 4'hf) begin
          nb_r <= nb_r + 4'h1;
        end
      end
    end
  end

  // ********
  // Assertions
  // ********
  AST_RST_OE: assert property (disable iff (1'b0)
    $past(rst) |-> !ctl_scl_oe && !ctl_sda_oe && !tgt_sda_oe && !tgt_irq_oe)
    else $error("drive enabled during reset");
  AST_IDLE_HIGH: assert property (
    !busy_r && !start |-> scl && sda) else $error("idle bus not high");
  AST_TGT_CHG: assert property (
    $changed(tgt_sda_oe) |-> !scl) else $error("target SDA moved, SCL high");
  AST_SCL_HIGH: assert property (
    $rose(scl) |=> scl [*8]) else $error("SCL high phase too short");
  AST_SCL_LOW: assert property (
    $fell(scl) |-> ##[9:11] $rose(scl)) else $error("SCL low phase wrong");
  AST_ACK_HOLD: assert property (
    $rose(scl) && tgt_sda_oe |=> tgt_sda_oe [*8])
    else $error("target dropped SDA in high phase");
  AST_ADDR_QUIET: assert property (
    nb_r < 4'h8 || (nb_r == 4'h8 && scl_d_r) |-> !tgt_sda_oe)
    else $error("target drove SDA inside first byte");
  AST_SDA_OD: assert property (
    tgt_sda_oe |-> !tgt_sda_o && !sda) else $error("SDA not pulled low");
  AST_IRQ_OD: assert property (
    tgt_irq_oe |-> !tgt_irq_o && !irq_n) else $error("irq_n not low");
endmodule : qui_chk

// ===== dv/quad_uart_i2c_target_port_tb.sv
// Bench: controller end runs transfers into the target end.
// Assumes both ends share one 10 MHz clock, straps both grounded.
`timescale 1ns/1ps

module quad_uart_i2c_target_port_tb;
  import qui_pkg::*;
  logic        ref_clk, rst, clk_en, cmd_valid, cmd_read;
  logic        cmd_ready, wr_take, rd_valid, done, err, irq_seen;
  logic        reg_wr, reg_rd;
  logic [1:0]  reg_uart;
  logic [3:0]  uart_event;
  logic [6:0]  cmd_dev;
  logic [7:0]  cmd_reg, cmd_len, wr_data, rd_data, reg_rdata;
  logic [7:0]  reg_addr, reg_wdata;
  logic [17:0] wq[$];
  int          n_mismatch, checked, j;

  qui_if bus_if();
  qui_target qui_target_i (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
    .bus(bus_if), .address_strap_upper(QUI_STRAP_GND),
    .address_strap_lower(QUI_STRAP_GND), .uart_event(uart_event),
    .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_uart(reg_uart), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  qui_ctrl qui_ctrl_i (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
    .bus(bus_if), .cmd_valid(cmd_valid), .cmd_read(cmd_read),
    .cmd_dev(cmd_dev), .cmd_reg(cmd_reg), .cmd_len(cmd_len),
    .wr_data(wr_data), .cmd_ready(cmd_ready), .wr_take(wr_take),
    .rd_data(rd_data), .rd_valid(rd_valid), .done(done), .err(err),
    .irq_seen(irq_seen));
  qui_chk qui_chk_i (.ref_clk(ref_clk), .rst(rst), .scl(bus_if.scl),
    .sda(bus_if.sda), .irq_n(bus_if.irq_n),
    .ctl_scl_oe(bus_if.ctl_scl_oe), .ctl_sda_oe(bus_if.ctl_sda_oe),
    .tgt_sda_o(bus_if.tgt_sda_o), .tgt_sda_oe(bus_if.tgt_sda_oe),
    .tgt_irq_o(bus_if.tgt_irq_o), .tgt_irq_oe(bus_if.tgt_irq_oe));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // ********
  // Register side model and capture
  // ********
  // Reads come back as address xor 0x5a; captured reads carry 0x3ff
  always @(negedge ref_clk) begin
    reg_rdata <= reg_addr ^ 8'h5a;
    if (reg_wr === 1'b1) wq.push_back({reg_uart, reg_addr, reg_wdata});
    if (rd_valid === 1'b1) wq.push_back({10'h3ff, rd_data});
  end

  // ********
  // Tasks
  // ********
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic lim(input int i, input int n);
    if (i >= n) begin
      n_mismatch++;
      close_out();
    end
  endtask : lim

  task automatic pop_w(input logic [17:0] e);
    logic [17:0] g;
    g = 18'hx;
    if (wq.size() > 0) g = wq.pop_front();
    chk(32'(g), 32'(e));
  endtask : pop_w

  task automatic xfer(input logic rd, input logic [6:0] dev,
                      input logic [7:0] rg, input logic [7:0] n,
                      input logic [7:0] d0, input logic e_err);
    int i;
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_dev = dev;
    cmd_reg = rg;
    cmd_len = n;
    wr_data = d0;
    for (i = 0; i < 100 && cmd_ready !== 1'b1; i++) @(negedge ref_clk);
    lim(i, 100);
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    // Next write byte follows each consumed one; one driver for wr_data
    for (i = 0; i < 6000 && done !== 1'b1; i++) begin
      if (wr_take === 1'b1) wr_data = wr_data + 8'h11;
      @(negedge ref_clk);
    end
    lim(i, 6000);
    chk(32'(err), 32'(e_err));
  endtask : xfer

  // ********
  // Main sequence
  // ********
  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_dev = 7'h00;
    cmd_reg = 8'h00;
    cmd_len = 8'h00;
    wr_data = 8'h00;
    uart_event = 4'h0;
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    repeat (12) @(negedge ref_clk);
    chk(32'({bus_if.scl, bus_if.sda, bus_if.irq_n}), 32'h7);
    xfer(1'b0, 7'h6c, 8'h25, 8'h01, 8'ha5, 1'b0);
    pop_w({2'h0, 8'h25, 8'ha5});
    xfer(1'b0, 7'h5c, 8'h10, 8'h03, 8'h31, 1'b0);
    for (j = 0; j < 3; j++) begin
      pop_w({2'h1, 8'(8'h10 + j), 8'(8'h31 + 8'h11 * j)});
    end
    xfer(1'b0, 7'h2c, 8'h00, 8'h02, 8'h0f, 1'b0);
    for (j = 0; j < 2; j++) begin
      pop_w({2'h2, 8'h00, 8'(8'h0f + 8'h11 * j)});
    end
    xfer(1'b0, 7'h6c, 8'h26, 8'h01, 8'h77, 1'b1);
    xfer(1'b0, 7'h7f, 8'h01, 8'h01, 8'h77, 1'b1);
    chk(32'(wq.size()), 32'h0);
    xfer(1'b1, 7'h1c, 8'h20, 8'h03, 8'h00, 1'b0);
    for (j = 0; j < 3; j++) pop_w({10'h3ff, 8'(8'h20 + j) ^ 8'h5a});
    chk(32'(reg_uart), 32'h3);
    xfer(1'b1, 7'h6c, 8'h25, 8'h01, 8'h00, 1'b0);
    pop_w({10'h3ff, 8'h7f});
    xfer(1'b1, 7'h2c, 8'h00, 8'h02, 8'h00, 1'b0);
    for (j = 0; j < 2; j++) pop_w({10'h3ff, 8'h5a});
    chk(32'(reg_uart), 32'h2);
    // Frozen clock enable must hold the interrupt line idle
    clk_en = 1'b0;
    uart_event = 4'h8;
    repeat (8) @(negedge ref_clk);
    chk(32'(bus_if.irq_n), 32'h1);
    clk_en = 1'b1;
    for (j = 0; j < 20 && irq_seen !== 1'b1; j++) @(negedge ref_clk);
    lim(j, 20);
    chk(32'(bus_if.irq_n), 32'h0);
    uart_event = 4'h0;
    for (j = 0; j < 20 && irq_seen !== 1'b0; j++) @(negedge ref_clk);
    lim(j, 20);
    chk(32'(bus_if.irq_n), 32'h1);
    chk(32'(wq.size()), 32'h0);
    close_out();
  end
endmodule : quad_uart_i2c_target_port_tb
